// [logic/lstrg_edge.sv]
`timescale 1ns/100ps
`default_nettype none
module lstrg_edge
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Signal
    input wire logic din,
    output logic level,
    output logic rise
);
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // Copy leaves at the same stage as the edge, so outputs stay aligned
    assign level = s2;
    assign rise = s2 & ~s3;
endmodule
`default_nettype wire

// [logic/lstrg_params.svh]
`ifndef LSTRG_PARAMS_SVH
`define LSTRG_PARAMS_SVH
`define LSTRG_REG_PRESCALE_LOW 4'h0
`define LSTRG_REG_PRESCALE_HIGH 4'h1
`define LSTRG_REG_RATE_LOW 4'h2
`define LSTRG_REG_RATE_HIGH 4'h3
`define LSTRG_REG_VETO_LENGTH 4'h4
`define LSTRG_REG_CAPTURE_CMD 4'hD
`define LSTRG_REG_TICK_LOW 4'hE
`define LSTRG_REG_TICK_HIGH 4'hF
`define LSTRG_LAMP_BIT 4
`define LSTRG_DIODE_BIT 5
`define LSTRG_OUT_VETO 0
`define LSTRG_OUT_FIRE 1
`define LSTRG_OUT_LAMP 2
`define LSTRG_OUT_DIODE 3
`define LSTRG_OUT_PERIODIC 14
`define LSTRG_OUT_RANDOM 15
`define LSTRG_RATE_SHIFT 24
`define LSTRG_LFSR_SEED 128'h0123456789ABCDEF0FEDCBA987654321
`endif

// [logic/lstrg_pkg.sv]
package lstrg_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } lstrg_bus_t;
    typedef struct packed {
        logic random;
        logic periodic;
        logic [9:0] unused;
        logic diode;
        logic lamp;
        logic fire;
        logic veto;
    } lstrg_out_t;
endpackage

// [logic/lstrg_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lstrg_params.svh"
module lstrg_top
#(
    parameter int CHANNELS = 8,
    parameter int LFSR_W = 128
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Mode
    input wire logic run,
    // Trigger inputs
    input wire logic [CHANNELS*16-1:0] chan_in,
    // Register port
    input wire lstrg_pkg::lstrg_bus_t bus,
    output logic [15:0] rdata,
    // Trigger outputs
    output logic [31:0] trig_out
);
    // Feedback taps and seed serve a 128-bit register only
    if (CHANNELS < 1 || LFSR_W != 128)
    begin
        $error("lstrg_top: unsupported parameters");
    end

    logic [15:0] prescale_low;
    logic [15:0] prescale_high;
    logic [11:0] rate_low;
    logic [11:0] rate_high;
    logic [15:0] veto_len;
    logic [23:0] tick_snap;
    logic [23:0] tick_count;
    logic run_q;
    logic [15:0] veto_cnt;
    logic [31:0] down_cnt;
    logic [31:0] decay;
    logic [LFSR_W-1:0] lfsr;
    lstrg_pkg::lstrg_out_t outv;

    // Input selection and edges
    wire lamp_raw = chan_in[`LSTRG_LAMP_BIT];
    wire diode_raw = chan_in[`LSTRG_DIODE_BIT];
    wire lamp_lvl;
    wire lamp_rise;
    wire diode_lvl;
    wire diode_rise;
    lstrg_edge u_lamp
    (
        .clk(clk),
        .nrst(nrst),
        .din(lamp_raw),
        .level(lamp_lvl),
        .rise(lamp_rise)
    );
    lstrg_edge u_diode
    (
        .clk(clk),
        .nrst(nrst),
        .din(diode_raw),
        .level(diode_lvl),
        .rise(diode_rise)
    );

    // Register decode
    wire wr_presc_lo = bus.wr && bus.addr == `LSTRG_REG_PRESCALE_LOW;
    wire wr_presc_hi = bus.wr && bus.addr == `LSTRG_REG_PRESCALE_HIGH;
    wire wr_rate_lo = bus.wr && bus.addr == `LSTRG_REG_RATE_LOW;
    wire wr_rate_hi = bus.wr && bus.addr == `LSTRG_REG_RATE_HIGH;
    wire wr_veto = bus.wr && bus.addr == `LSTRG_REG_VETO_LENGTH;
    wire wr_capture = bus.wr && bus.addr == `LSTRG_REG_CAPTURE_CMD;
    wire [15:0] rd_mux =
        (bus.addr == `LSTRG_REG_PRESCALE_LOW) ? prescale_low :
        (bus.addr == `LSTRG_REG_PRESCALE_HIGH) ? prescale_high :
        (bus.addr == `LSTRG_REG_RATE_LOW) ? {4'h0, rate_low} :
        (bus.addr == `LSTRG_REG_RATE_HIGH) ? {4'h0, rate_high} :
        (bus.addr == `LSTRG_REG_VETO_LENGTH) ? veto_len :
        (bus.addr == `LSTRG_REG_TICK_LOW) ? {4'h0, tick_snap[11:0]} :
        (bus.addr == `LSTRG_REG_TICK_HIGH) ? {4'h0, tick_snap[23:12]} :
        16'h0000;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prescale_low <= 16'h0000;
            prescale_high <= 16'h0000;
            rate_low <= 12'h000;
            rate_high <= 12'h000;
            veto_len <= 16'h0000;
            rdata <= 16'h0000;
        end
        else
        begin
            if (wr_presc_lo)
                prescale_low <= bus.wdata;
            if (wr_presc_hi)
                prescale_high <= bus.wdata;
            if (wr_rate_lo)
                rate_low <= bus.wdata[11:0];
            if (wr_rate_hi)
                rate_high <= bus.wdata[11:0];
            if (wr_veto)
                veto_len <= bus.wdata;
            rdata <= bus.rd ? rd_mux : 16'h0000;
        end
    end

    // Tick counter and capture
    wire run_entry = run && !run_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            run_q <= 1'b0;
            tick_count <= 24'h000000;
            tick_snap <= 24'h000000;
        end
        else
        begin
            run_q <= run;
            if (run_entry)
                tick_count <= 24'h000000;
            else
                tick_count <= tick_count + 24'h000001;
            if (wr_capture)
                tick_snap <= tick_count;
        end
    end

    // Veto window
    // First window tick comes straight from the edge, the counter covers the rest
    wire veto_start = lamp_rise && veto_len != 16'h0000;
    wire [15:0] next_veto_cnt = veto_start ? veto_len - 16'h0001 :
        (veto_cnt != 16'h0000) ? veto_cnt - 16'h0001 : 16'h0000;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            veto_cnt <= 16'h0000;
        else
            veto_cnt <= next_veto_cnt;
    end

    // Periodic trigger
    wire [31:0] prescale = {prescale_high, prescale_low};
    wire presc_on = prescale != 32'h00000000;
    wire periodic_hit = presc_on && down_cnt == 32'h00000001;
    always_ff @(posedge clk)
    begin
        if (!nrst || !presc_on || run_entry)
            down_cnt <= prescale;
        else if (periodic_hit || down_cnt == 32'h00000000)
            down_cnt <= prescale;
        else
            down_cnt <= down_cnt - 32'h00000001;
    end

    // Random trigger
    wire [23:0] rate = {rate_high, rate_low};
    wire rand_on = rate != 24'h000000;
    wire [55:0] decay_prod = 56'(decay) * 56'(rate);
    wire [31:0] decay_step = decay_prod[55:`LSTRG_RATE_SHIFT];
    wire [31:0] threshold = lfsr[31:0];
    wire random_hit = rand_on && decay < threshold;
    wire lfsr_fb = lfsr[127] ^ lfsr[125] ^ lfsr[100] ^ lfsr[98];
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            decay <= 32'hFFFFFFFF;
            lfsr <= LFSR_W'(`LSTRG_LFSR_SEED);
        end
        else if (!rand_on)
            decay <= 32'hFFFFFFFF;
        else if (random_hit)
        begin
            decay <= 32'hFFFFFFFF;
            lfsr <= {lfsr[LFSR_W-2:0], lfsr_fb};
        end
        else
            decay <= decay - decay_step;
    end

    // Output assembly
    always_comb
    begin
        outv = '0;
        outv.veto = veto_start || veto_cnt != 16'h0000;
        outv.fire = diode_rise;
        outv.lamp = lamp_lvl;
        outv.diode = diode_lvl;
        outv.periodic = periodic_hit;
        outv.random = random_hit;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
            trig_out <= 32'h00000000;
        else
            trig_out <= {outv, outv};
    end
endmodule
`default_nettype wire

// [sim/lstrg_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module lstrg_checker
#(
    parameter int CHANNELS = 8
)
(
    // Clock, reset
    input wire logic clk,
    input wire logic nrst,
    // Inputs
    input wire logic run,
    input wire logic [CHANNELS*16-1:0] chan_in,
    input wire lstrg_pkg::lstrg_bus_t bus,
    // Outputs
    input wire logic [15:0] rdata,
    input wire logic [31:0] trig_out
);
    logic [1:0] up;
    logic veto_on;
    always_ff @(posedge clk)
        if (!nrst) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    always_ff @(posedge clk)
        if (!nrst) veto_on <= 1'b0;
        else if (bus.wr && bus.addr == 4'h4) veto_on <= bus.wdata != 16'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    dup_half_a: assert property (trig_out[31:16] == trig_out[15:0])
        else $error("halves differ");
    spare_low_a: assert property (trig_out[13:4] == 10'h0)
        else $error("spare bits set");
    fire_once_a: assert property (trig_out[1] |=> !trig_out[1])
        else $error("fire too long");
    fire_cause_a: assert property ($rose(chan_in[5]) |-> ##3 trig_out[1])
        else $error("fire missing");
    copy_align_a: assert property (up == 2'h3 |-> trig_out[3:2] == $past(chan_in[5:4], 3))
        else $error("copy wrong");
    veto_start_a: assert property ($rose(chan_in[4]) && veto_on |-> ##3 trig_out[0])
        else $error("veto missing");
    rd_idle_a: assert property (up != 2'h0 && !$past(bus.rd) |-> rdata == 16'h0)
        else $error("stray read data");
    cmd_read_a: assert property (bus.rd && bus.addr == 4'hD |=> rdata == 16'h0)
        else $error("command reads data");
    rand_once_a: assert property (trig_out[15] |=> !trig_out[15])
        else $error("random too long");
    cover property (trig_out[0]);
    cover property (trig_out[14]);
    cover property (trig_out[15]);
endmodule
bind lstrg_top lstrg_checker #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .nrst(nrst), .run(run),
    .chan_in(chan_in), .bus(bus), .rdata(rdata), .trig_out(trig_out));
`default_nettype wire

// [sim/lstrg_laser_src.sv]
`timescale 1ns/100ps
`default_nettype none
module lstrg_laser_src
(
    // Clock
    input wire logic clk,
    // Request
    input wire logic go,
    // Channels
    output logic [127:0] chan
);
    logic [4:0] t;
    initial t = 5'h1F;
    initial chan = '0;
    always @(posedge clk)
    begin
        if (go) t <= 5'h0;
        else if (t != 5'h1F) t <= t + 5'h1;
        chan <= {~chan[127:6], t == 5'h2 || t == 5'h3, t < 5'h4, ~chan[3:0]};
    end
endmodule
`default_nettype wire

// [sim/tb_laser_and_special_trigger_logic.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_laser_and_special_trigger_logic;
    typedef struct { logic [3:0] a; logic [15:0] d; logic [15:0] e; } lstrg_row_t;
    logic clk, nrst, run, go;
    logic [127:0] chan_in;
    lstrg_pkg::lstrg_bus_t bus;
    logic [15:0] rdata, q;
    logic [31:0] trig_out;
    int err_count, comparisons, n;
    logic [15:0] lx[4] = '{16'h5, 16'h1, 16'h4, 16'h2};
    lstrg_row_t rows[7] = '{'{4'h0, 16'hABCD, 16'hABCD}, '{4'h1, 16'h0012, 16'h0012},
        '{4'h2, 16'h0ABC, 16'h0ABC}, '{4'h3, 16'h0123, 16'h0123}, '{4'h4, 16'h5, 16'h5},
        '{4'h5, 16'hBEEF, 16'h0}, '{4'hD, 16'h1, 16'h0}};
    lstrg_top dut (.clk(clk), .nrst(nrst), .run(run), .chan_in(chan_in), .bus(bus),
        .rdata(rdata), .trig_out(trig_out));
    lstrg_laser_src src (.clk(clk), .go(go), .chan(chan_in));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task acc(input logic [3:0] a, input logic [15:0] d, input logic w);
        bus <= '{a, d, w, !w};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
        q = rdata;
    endtask
    task cnt(input int b, input int c);
        n = 0;
        repeat (c)
        begin
            @(posedge clk);
            n += trig_out[b];
        end
    endtask
    task cap(input int k, input logic [15:0] lo, input logic [15:0] hi);
        run <= 1'b0;
        @(posedge clk);
        run <= 1'b1;
        repeat (k) @(posedge clk);
        acc(4'hD, 16'h1, 1'b1);
        acc(4'hE, 16'h0, 1'b0);
        chk(q, lo);
        acc(4'hF, 16'h0, 1'b0);
        chk(q, hi);
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        end_of_test;
    end
    initial
    begin
        nrst = 1'b0;
        run = 1'b0;
        go = 1'b0;
        bus = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        acc(4'h0, 16'h0, 1'b0);
        chk(q, 16'h0);
        foreach (rows[i])
        begin
            acc(rows[i].a, rows[i].d, 1'b1);
            acc(rows[i].a, 16'h0, 1'b0);
            chk(q, rows[i].e);
        end
        for (int b = 0; b < 5; b++)
        begin
            if (b == 4) acc(4'h4, 16'h0, 1'b1);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            cnt(b % 4, 20);
            chk(16'(n), b == 4 ? 16'h0 : lx[b]);
        end
        acc(4'h1, 16'h0, 1'b1);
        acc(4'h0, 16'h0, 1'b1);
        cnt(14, 20);
        chk(16'(n), 16'h0);
        acc(4'h0, 16'h3, 1'b1);
        cnt(14, 10);
        cnt(14, 30);
        chk(16'(n), 16'hA);
        acc(4'h0, 16'h1, 1'b1);
        cnt(14, 5);
        cnt(14, 10);
        chk(16'(n), 16'hA);
        acc(4'h2, 16'h0, 1'b1);
        acc(4'h3, 16'h0, 1'b1);
        cnt(15, 5);
        cnt(15, 50);
        chk(16'(n), 16'h0);
        acc(4'h2, 16'hFFF, 1'b1);
        acc(4'h3, 16'hFFF, 1'b1);
        cnt(15, 200);
        chk(16'(n != 0), 16'h1);
        cap(1, 16'h0, 16'h0);
        cap(5000, 16'h387, 16'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(trig_out[15:0], 16'h0);
        acc(4'h2, 16'h0, 1'b0);
        chk(q, 16'h0);
        cnt(14, 20);
        chk(16'(n), 16'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
